// *** logic/otw_defs.vh ***
// Constants for the overtravel limit and warning block
`ifndef OTW_DEFS_VH
`define OTW_DEFS_VH

`define OTW_AW              8
`define OTW_DW              16
`define OTW_TW              10

`define OTW_ADDR_ALLOC_A    8'h00
`define OTW_ADDR_ALLOC_B    8'h04
`define OTW_ADDR_STOP       8'h08
`define OTW_ADDR_ESTOP      8'h0C
`define OTW_ADDR_WARN       8'h10
`define OTW_ADDR_STATUS     8'h14
`define OTW_ADDR_CTRL       8'h18

`define OTW_ALLOC_A_RST     16'h2000
`define OTW_ALLOC_B_RST     16'h0003
`define OTW_STOP_RST        16'h0002
`define OTW_STOP_SEL_RST    8'h02
`define OTW_ESTOP_RST       16'h0320
`define OTW_WARN_RST        16'h0000

`define OTW_LIM_DISABLE     4'h8
`define OTW_STOP_DEC_CLAMP  8'h10
`define OTW_STOP_DEC_COAST  8'h20
`define OTW_WARN_ON         4'h1
`define OTW_ESTOP_MAX       10'h320

`define OTW_CTRL_RESTART    0
`define OTW_ST_FWD_OT       0
`define OTW_ST_REV_OT       1
`define OTW_ST_WARN         2
`define OTW_ST_DECEL        3
`define OTW_ST_CLAMP        4
`define OTW_ST_COAST        5
`define OTW_ST_HOLD_ERR     6
`define OTW_ST_FWD_USED     7
`define OTW_ST_REV_USED     8

`define OTW_HOLD_MS         1000
`define OTW_CLK_KHZ         20000
// One second of the 20 MHz clock, sized to the hold counter
`define OTW_HOLD_CYC        25'h131_2D00
`define OTW_CNT_W           25

`endif

// *** logic/otw_hold_timer.v ***
// Down counter that keeps the overtravel warning alive after the condition ends
`timescale 1ns/100ps
`include "otw_defs.vh"

module otw_hold_timer
#(
   parameter [`OTW_CNT_W-1:0] HOLD_CYC = `OTW_HOLD_CYC
)
(
   input  wire ref_clk,
   input  wire resetn,
   input  wire load,
   output reg  done_r
);

   reg [`OTW_CNT_W-1:0] cnt_r;
   wire                 last;

   assign last = (cnt_r == {{(`OTW_CNT_W-1){1'b0}}, 1'b1});

   // Reloading every cycle while overtravel lasts makes the hold start at its end
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_r  <= {`OTW_CNT_W{1'b0}};
         done_r <= 1'b0;
      end
      else
      begin
         done_r <= last & ~load;
         if (load)
            cnt_r <= HOLD_CYC;
         else if (cnt_r != {`OTW_CNT_W{1'b0}})
            cnt_r <= cnt_r - {{(`OTW_CNT_W-1){1'b0}}, 1'b1};
      end
   end

endmodule // otw_hold_timer

// *** logic/otw_overtravel.v ***
// Overtravel limit stop control and overtravel warning
`timescale 1ns/100ps
`include "otw_defs.vh"

module otw_overtravel
#(
   parameter [`OTW_CNT_W-1:0] HOLD_CYC = `OTW_HOLD_CYC
)
(
   input  wire                 ref_clk,
   input  wire                 resetn,
   input  wire [`OTW_AW-1:0]   addr,
   input  wire [`OTW_DW-1:0]   wdata,
   input  wire                 wr,
   input  wire                 rd,
   output reg  [`OTW_DW-1:0]   rdata_r,
   input  wire                 fwd_limit_in,
   input  wire                 rev_limit_in,
   input  wire                 pos_error_clear_in,
   input  wire                 servo_on_in,
   input  wire                 ref_fwd_in,
   input  wire                 ref_rev_in,
   input  wire                 torque_mode_in,
   input  wire                 pos_mode_in,
   input  wire                 motor_stopped_in,
   input  wire [`OTW_TW-1:0]   motor_max_torque_in,
   output reg                  fwd_allow_r,
   output reg                  rev_allow_r,
   output wire                 decel_out,
   output wire                 zero_clamp_out,
   output wire                 coast_out,
   output reg  [`OTW_TW-1:0]   estop_torque_r,
   output reg                  hold_pos_error_r,
   output reg                  ot_warning_r
);

   localparam [1:0] ST_RUN   = 2'b00;
   localparam [1:0] ST_DECEL = 2'b01;
   localparam [1:0] ST_CLAMP = 2'b10;
   localparam [1:0] ST_COAST = 2'b11;

   // Configuration as written by software (estop torque clamped); only the alloc and stop fields are staged
   reg  [`OTW_DW-1:0] input_alloc_cfg_a_r;
   reg  [`OTW_DW-1:0] input_alloc_cfg_b_r;
   reg  [`OTW_DW-1:0] stop_method_cfg_r;
   reg  [`OTW_TW-1:0] estop_torque_cfg_r;
   reg  [`OTW_DW-1:0] ot_warning_cfg_r;

   // Active copies of the restart-only settings
   reg                fwd_used_r;
   reg                rev_used_r;
   reg  [7:0]         stop_sel_r;

   reg                fwd_s1_r;
   reg                fwd_s2_r;
   reg                rev_s1_r;
   reg                rev_s2_r;

   reg  [1:0]         state_r;
   reg  [1:0]         state_nxt;
   reg                wcond_prev_r;
   reg                servo_prev_r;
   reg                restart_r;

   wire               fwd_ot;
   wire               rev_ot;
   wire               ot_any;
   wire               stop_hit;
   wire               fwd_hit;
   wire               rev_hit;
   wire               wcond;
   wire               warn_en;
   wire               new_evt;
   wire               timer_load;
   wire               timer_done;
   wire               sel_coast;
   wire [`OTW_DW-1:0] status;
   wire [`OTW_TW-1:0] wdata_trq;

   // A limit digit disables its input only at the disable code
   function lim_used;
      input [3:0] digit;
      begin
         lim_used = (digit != `OTW_LIM_DISABLE);
      end
   endfunction

   function [`OTW_TW-1:0] min_trq;
      input [`OTW_TW-1:0] a;
      input [`OTW_TW-1:0] b;
      begin
         min_trq = (a < b) ? a : b;
      end
   endfunction

   function is_hit;
      input ot;
      input opposite_ref;
      begin
         is_hit = ot & ~opposite_ref;
      end
   endfunction

   // Two flops per switch; only the second stage is looked at
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         fwd_s1_r <= 1'b1;
         fwd_s2_r <= 1'b1;
         rev_s1_r <= 1'b1;
         rev_s2_r <= 1'b1;
      end
      else
      begin
         fwd_s1_r <= fwd_limit_in;
         fwd_s2_r <= fwd_s1_r;
         rev_s1_r <= rev_limit_in;
         rev_s2_r <= rev_s1_r;
      end
   end

   // Switch off means overtravel; a disabled input never reports it
   assign fwd_ot = fwd_used_r & ~fwd_s2_r;
   assign rev_ot = rev_used_r & ~rev_s2_r;
   assign ot_any = fwd_ot | rev_ot;

   // A reference away from the limit is not a stop cause
   assign fwd_hit  = is_hit(fwd_ot, ref_rev_in);
   assign rev_hit  = is_hit(rev_ot, ref_fwd_in);
   assign stop_hit = servo_on_in & (fwd_hit | rev_hit);

   assign sel_coast = (stop_sel_r != `OTW_STOP_DEC_CLAMP) &&
                      (stop_sel_r != `OTW_STOP_DEC_COAST);
   assign wdata_trq = (wdata[`OTW_TW-1:0] > `OTW_ESTOP_MAX) ?
                      `OTW_ESTOP_MAX : wdata[`OTW_TW-1:0];

   // Register writes; restart-only fields are staged here
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         input_alloc_cfg_a_r <= `OTW_ALLOC_A_RST;
         input_alloc_cfg_b_r <= `OTW_ALLOC_B_RST;
         stop_method_cfg_r   <= `OTW_STOP_RST;
         estop_torque_cfg_r  <= `OTW_ESTOP_MAX;
         ot_warning_cfg_r    <= `OTW_WARN_RST;
         restart_r           <= 1'b0;
      end
      else
      begin
         restart_r <= wr && (addr == `OTW_ADDR_CTRL) && wdata[`OTW_CTRL_RESTART];
         if (wr)
         begin
            case (addr)
               `OTW_ADDR_ALLOC_A : input_alloc_cfg_a_r <= wdata;
               `OTW_ADDR_ALLOC_B : input_alloc_cfg_b_r <= wdata;
               `OTW_ADDR_STOP    : stop_method_cfg_r   <= wdata;
               `OTW_ADDR_ESTOP   : estop_torque_cfg_r  <= wdata_trq;
               `OTW_ADDR_WARN    : ot_warning_cfg_r    <= wdata;
               default           : ;
            endcase
         end
      end
   end

   // Applying at restart keeps a running axis from changing behaviour mid-stroke
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         fwd_used_r <= 1'b1;
         rev_used_r <= 1'b1;
         stop_sel_r <= `OTW_STOP_SEL_RST;
      end
      else if (restart_r)
      begin
         fwd_used_r <= lim_used(input_alloc_cfg_a_r[15:12]);
         rev_used_r <= lim_used(input_alloc_cfg_b_r[3:0]);
         stop_sel_r <= stop_method_cfg_r[7:0];
      end
   end

   // Stop sequence
   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         ST_RUN:
         begin
            if (stop_hit)
            begin
               if (torque_mode_in || sel_coast)
                  state_nxt = ST_COAST;
               else
                  state_nxt = ST_DECEL;
            end
         end
         ST_DECEL:
         begin
            if (!stop_hit)
               state_nxt = ST_RUN;
            else if (torque_mode_in)
               state_nxt = ST_COAST;
            else if (motor_stopped_in)
            begin
               if (stop_sel_r == `OTW_STOP_DEC_CLAMP)
                  state_nxt = ST_CLAMP;
               else
                  state_nxt = ST_COAST;
            end
         end
         ST_CLAMP:
         begin
            if (!stop_hit)
               state_nxt = ST_RUN;
            else if (torque_mode_in)
               state_nxt = ST_COAST;
         end
         ST_COAST:
         begin
            if (!stop_hit)
               state_nxt = ST_RUN;
         end
         default:
            state_nxt = ST_RUN;
      endcase
   end

   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         state_r <= ST_RUN;
      else
         state_r <= state_nxt;
   end

   assign decel_out      = (state_r == ST_DECEL);
   assign zero_clamp_out = (state_r == ST_CLAMP);
   assign coast_out      = (state_r == ST_COAST);

   // Motion permission and emergency stop torque
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         fwd_allow_r    <= 1'b1;
         rev_allow_r    <= 1'b1;
         estop_torque_r <= {`OTW_TW{1'b0}};
      end
      else
      begin
         fwd_allow_r    <= ~fwd_ot;
         rev_allow_r    <= ~rev_ot;
         // Setting changes apply on the next edge, even mid-deceleration
         estop_torque_r <= min_trq(estop_torque_cfg_r, motor_max_torque_in);
      end
   end

   // Error pulses stay until the host clears; a new stop in the same cycle wins
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         hold_pos_error_r <= 1'b0;
      else if ((state_r == ST_RUN) && (state_nxt != ST_RUN) && pos_mode_in)
         hold_pos_error_r <= 1'b1;
      else if (pos_error_clear_in)
         hold_pos_error_r <= 1'b0;
   end

   // Warning detection; it has no path into the stop sequence above
   assign warn_en    = (ot_warning_cfg_r[15:12] == `OTW_WARN_ON);
   assign wcond      = servo_on_in & (fwd_hit | rev_hit);
   assign new_evt    = warn_en & wcond & ~wcond_prev_r & servo_prev_r;
   assign timer_load = new_evt | (ot_warning_r & ot_any);

   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wcond_prev_r <= 1'b0;
         servo_prev_r <= 1'b0;
      end
      else
      begin
         wcond_prev_r <= wcond;
         servo_prev_r <= servo_on_in;
      end
   end

   otw_hold_timer
   #(
      .HOLD_CYC (HOLD_CYC)
   )
   u_hold
   (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .load    (timer_load),
      .done_r  (timer_done)
   );

   // A new occurrence beats an expiry landing in the same cycle
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         ot_warning_r <= 1'b0;
      else if (new_evt)
         ot_warning_r <= 1'b1;
      else if (timer_done || !warn_en)
         ot_warning_r <= 1'b0;
   end

   // Status and read-back
   assign status = {7'h00,
                    rev_used_r,
                    fwd_used_r,
                    hold_pos_error_r,
                    coast_out,
                    zero_clamp_out,
                    decel_out,
                    ot_warning_r,
                    rev_ot,
                    fwd_ot};

   // Read data stand only in the cycle after the strobe
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         rdata_r <= {`OTW_DW{1'b0}};
      else if (rd)
      begin
         case (addr)
            `OTW_ADDR_ALLOC_A : rdata_r <= input_alloc_cfg_a_r;
            `OTW_ADDR_ALLOC_B : rdata_r <= input_alloc_cfg_b_r;
            `OTW_ADDR_STOP    : rdata_r <= stop_method_cfg_r;
            `OTW_ADDR_ESTOP   : rdata_r <= {6'h00, estop_torque_cfg_r};
            `OTW_ADDR_WARN    : rdata_r <= ot_warning_cfg_r;
            `OTW_ADDR_STATUS  : rdata_r <= status;
            default           : rdata_r <= {`OTW_DW{1'b0}};
         endcase
      end
      else
         rdata_r <= {`OTW_DW{1'b0}};
   end

endmodule // otw_overtravel

// *** sim/otw_overtravel_monitor.sv ***
// Concurrent checks on the overtravel block ports
`timescale 1ns/100ps
`include "otw_defs.vh"

module otw_overtravel_monitor
#(
   parameter [`OTW_CNT_W-1:0] HOLD_CYC = `OTW_HOLD_CYC
)
(
   input wire                ref_clk,
   input wire                resetn,
   input wire [`OTW_AW-1:0]  addr,
   input wire [`OTW_DW-1:0]  wdata,
   input wire                wr,
   input wire                rd,
   input wire [`OTW_DW-1:0]  rdata_r,
   input wire                fwd_limit_in,
   input wire                rev_limit_in,
   input wire                servo_on_in,
   input wire                torque_mode_in,
   input wire                pos_mode_in,
   input wire [`OTW_TW-1:0]  motor_max_torque_in,
   input wire                fwd_allow_r,
   input wire                rev_allow_r,
   input wire                decel_out,
   input wire                zero_clamp_out,
   input wire                coast_out,
   input wire [`OTW_TW-1:0]  estop_torque_r,
   input wire                hold_pos_error_r,
   input wire                ot_warning_r
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   reg [25:0] quiet_cnt_r;
   reg        clr_seen_r;

   // Cycles the warning has stood with both directions free again
   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         quiet_cnt_r <= 26'h000_0000;
         clr_seen_r  <= 1'b0;
      end
      else
      begin
         quiet_cnt_r <= (ot_warning_r && fwd_allow_r && rev_allow_r) ?
                        quiet_cnt_r + 26'h000_0001 : 26'h000_0000;
         clr_seen_r  <= wr && addr == `OTW_ADDR_WARN && wdata[15:12] != `OTW_WARN_ON;
      end
   end

   sequence s_fwd_on3;
      fwd_limit_in [*3];
   endsequence
   sequence s_rev_on3;
      rev_limit_in [*3];
   endsequence

   a_rdata_idle_zero: assert property (!$past(rd) |-> rdata_r == 16'h0000)
      else $error("read data not zero outside read answer");
   a_fwd_allow_on: assert property (s_fwd_on3 |=> fwd_allow_r)
      else $error("forward blocked while limit on");
   a_rev_allow_on: assert property (s_rev_on3 |=> rev_allow_r)
      else $error("reverse blocked while limit on");
   a_warn_needs_power: assert property ($rose(ot_warning_r) |-> $past(servo_on_in))
      else $error("warning raised with power off");
   a_warn_cfg_off: assert property (wr && addr == `OTW_ADDR_WARN && wdata[15:12] != `OTW_WARN_ON
      |-> ##[1:2] !ot_warning_r)
      else $error("warning not cleared by disable");
   a_estop_clamped: assert property (estop_torque_r <= `OTW_ESTOP_MAX && ($stable(motor_max_torque_in)
      -> estop_torque_r <= motor_max_torque_in))
      else $error("emergency torque above limit");
   a_stop_one_mode: assert property ($onehot0({decel_out, zero_clamp_out, coast_out}))
      else $error("more than one stop mode");
   a_clamp_after_decel: assert property ($rose(zero_clamp_out) |-> $past(decel_out))
      else $error("zero clamp entered without deceleration");
   a_hold_err_pos: assert property ($rose(hold_pos_error_r) |-> $past(pos_mode_in))
      else $error("position error held outside position control");
   a_torque_no_decel: assert property (torque_mode_in [*2] |=> !decel_out && !zero_clamp_out)
      else $error("deceleration under torque control");
   a_warn_hold_time: assert property ($fell(ot_warning_r) && !clr_seen_r && !$past(clr_seen_r)
      |-> quiet_cnt_r >= HOLD_CYC - 2)
      else $error("warning cleared too early");
   a_warn_expiry: assert property (quiet_cnt_r <= HOLD_CYC + 4)
      else $error("warning held too long");
endmodule // otw_overtravel_monitor

bind otw_overtravel otw_overtravel_monitor #(.HOLD_CYC(HOLD_CYC)) u_otw_overtravel_monitor (.*);

// *** sim/otw_motion_partner.sv ***
// Limit switches, motor standstill and host error clear around the block
`timescale 1ns/100ps

module otw_motion_partner
(
   input  wire       ref_clk,
   input  wire       resetn,
   input  wire       fwd_hit,
   input  wire       rev_hit,
   input  wire       clr_req,
   input  wire       decel_out,
   input  wire [3:0] stop_dly,
   output reg        fwd_limit_in,
   output reg        rev_limit_in,
   output reg        pos_error_clear_in,
   output reg        motor_stopped_in
);
   reg [3:0] dly_r;

   always @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         fwd_limit_in       <= 1'b1;
         rev_limit_in       <= 1'b1;
         pos_error_clear_in <= 1'b0;
         motor_stopped_in   <= 1'b0;
         dly_r              <= 4'h0;
      end
      else
      begin
         // Switch contact opens when the axis reaches the end stop
         fwd_limit_in       <= !fwd_hit;
         rev_limit_in       <= !rev_hit;
         pos_error_clear_in <= clr_req;
         // Slow or prompt standstill, so decel is seen for several cycles
         dly_r              <= decel_out ? dly_r + {3'h0, dly_r != stop_dly} : 4'h0;
         motor_stopped_in   <= decel_out && dly_r == stop_dly;
      end
   end
endmodule // otw_motion_partner

// *** sim/otw_overtravel_tb.sv ***
// Directed bench for the overtravel block
`timescale 1ns/100ps
`include "otw_defs.vh"

module otw_overtravel_tb;
   localparam [24:0] HOLD = 25'h000_0014;
   reg                ref_clk = 0, resetn = 0, wr = 0, rd = 0;
   reg  [7:0]         addr = 8'h00;
   reg  [15:0]        wdata = 16'h0000;
   reg                servo_on_in = 0, ref_fwd_in = 0, ref_rev_in = 0;
   reg                torque_mode_in = 0, pos_mode_in = 0;
   reg  [9:0]         motor_max_torque_in = 10'h3FF;
   reg                fwd_hit = 0, rev_hit = 0, clr_req = 0;
   reg  [3:0]         stop_dly = 4'h0;
   wire [15:0]        rdata_r;
   wire [9:0]         estop_torque_r;
   wire               fwd_limit_in, rev_limit_in, pos_error_clear_in, motor_stopped_in;
   wire               fwd_allow_r, rev_allow_r, decel_out, zero_clamp_out, coast_out;
   wire               hold_pos_error_r, ot_warning_r;
   integer            failures = 0, n_tests = 0, i;
   reg  [15:0]        tab [0:2];

   always #25 ref_clk = ~ref_clk;

   otw_overtravel #(.HOLD_CYC(HOLD)) u_otw_overtravel (.ref_clk(ref_clk), .resetn(resetn),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r),
      .fwd_limit_in(fwd_limit_in), .rev_limit_in(rev_limit_in),
      .pos_error_clear_in(pos_error_clear_in), .servo_on_in(servo_on_in),
      .ref_fwd_in(ref_fwd_in), .ref_rev_in(ref_rev_in), .torque_mode_in(torque_mode_in),
      .pos_mode_in(pos_mode_in), .motor_stopped_in(motor_stopped_in),
      .motor_max_torque_in(motor_max_torque_in), .fwd_allow_r(fwd_allow_r),
      .rev_allow_r(rev_allow_r), .decel_out(decel_out), .zero_clamp_out(zero_clamp_out),
      .coast_out(coast_out), .estop_torque_r(estop_torque_r),
      .hold_pos_error_r(hold_pos_error_r), .ot_warning_r(ot_warning_r));

   otw_motion_partner u_otw_motion_partner (.ref_clk(ref_clk), .resetn(resetn),
      .fwd_hit(fwd_hit), .rev_hit(rev_hit), .clr_req(clr_req), .decel_out(decel_out),
      .stop_dly(stop_dly), .fwd_limit_in(fwd_limit_in), .rev_limit_in(rev_limit_in),
      .pos_error_clear_in(pos_error_clear_in), .motor_stopped_in(motor_stopped_in));

   task wt(input integer n);
   begin
      repeat (n) @(posedge ref_clk);
      #1;
   end
   endtask

   task chk(input [15:0] got, input [15:0] exp);
   begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
         failures = failures + 1;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask

   task wreg(input [7:0] a, input [15:0] d);
   begin
      @(posedge ref_clk) begin wr <= 1; addr <= a; wdata <= d; end
      @(posedge ref_clk) wr <= 0;
   end
   endtask

   task rchk(input [7:0] a, input [15:0] exp);
   begin
      @(posedge ref_clk) begin rd <= 1; addr <= a; end
      @(posedge ref_clk) rd <= 0;
      #1 chk(rdata_r, exp);
   end
   endtask

   task conclude;
   begin
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   end
   endtask

   initial
   begin
      #(50 * 6000);
      failures = failures + 1;
      conclude;
   end

   initial
   begin
      repeat (20) @(posedge ref_clk);
      resetn <= 1;
      wt(3);
      rchk(`OTW_ADDR_ALLOC_A, `OTW_ALLOC_A_RST);
      rchk(`OTW_ADDR_ALLOC_B, `OTW_ALLOC_B_RST);
      rchk(`OTW_ADDR_STOP, `OTW_STOP_RST);
      rchk(`OTW_ADDR_ESTOP, `OTW_ESTOP_RST);
      rchk(`OTW_ADDR_WARN, `OTW_WARN_RST);
      rchk(8'h1C, 16'h0000);
      rchk(`OTW_ADDR_CTRL, 16'h0000);
      chk(estop_torque_r, 16'h0320);
      wreg(`OTW_ADDR_ESTOP, 16'h0384);
      rchk(`OTW_ADDR_ESTOP, 16'h0320);
      wreg(`OTW_ADDR_ESTOP, 16'h0100);
      wt(2);
      chk(estop_torque_r, 16'h0100);
      @(posedge ref_clk) motor_max_torque_in <= 10'h050;
      wt(3);
      chk(estop_torque_r, 16'h0050);
      $display("test estop done");
      @(posedge ref_clk) begin servo_on_in <= 1; pos_mode_in <= 1; end
      wt(2);
      @(posedge ref_clk) fwd_hit <= 1;
      wt(6);
      chk({fwd_allow_r, rev_allow_r, coast_out}, 16'h0003);
      chk(hold_pos_error_r, 16'h0001);
      chk(ot_warning_r, 16'h0000);
      @(posedge ref_clk) clr_req <= 1;
      @(posedge ref_clk) clr_req <= 0;
      wt(3);
      chk(hold_pos_error_r, 16'h0000);
      @(posedge ref_clk) fwd_hit <= 0;
      wt(6);
      chk({fwd_allow_r, coast_out}, 16'h0002);
      $display("test forward stop done");
      wreg(`OTW_ADDR_WARN, 16'h1000);
      @(posedge ref_clk) fwd_hit <= 1;
      @(posedge ref_clk) fwd_hit <= 0;
      wt(5);
      chk(ot_warning_r, 16'h0001);
      wt(HOLD - 6);
      chk(ot_warning_r, 16'h0001);
      wt(10);
      chk(ot_warning_r, 16'h0000);
      $display("test warning hold done");
      @(posedge ref_clk) begin ref_fwd_in <= 1; rev_hit <= 1; end
      wt(6);
      chk({fwd_allow_r, rev_allow_r, ot_warning_r}, 16'h0004);
      @(posedge ref_clk) ref_fwd_in <= 0;
      wt(4);
      chk(ot_warning_r, 16'h0001);
      wreg(`OTW_ADDR_WARN, 16'h0000);
      wt(2);
      chk(ot_warning_r, 16'h0000);
      @(posedge ref_clk) begin rev_hit <= 0; servo_on_in <= 0; end
      wreg(`OTW_ADDR_WARN, 16'h1000);
      @(posedge ref_clk) fwd_hit <= 1;
      wt(6);
      chk(ot_warning_r, 16'h0000);
      @(posedge ref_clk) servo_on_in <= 1;
      wt(6);
      chk(ot_warning_r, 16'h0000);
      @(posedge ref_clk) fwd_hit <= 0;
      wt(6);
      $display("test warning direction done");
      tab[0] = 16'h0010;
      tab[1] = 16'h0020;
      tab[2] = 16'h0110;
      for (i = 0; i < 3; i = i + 1)
      begin
         wreg(`OTW_ADDR_STOP, {8'h00, tab[i][7:0]});
         wreg(`OTW_ADDR_CTRL, 16'h0001);
         @(posedge ref_clk) begin torque_mode_in <= tab[i][8]; stop_dly <= 4'h9 - 4'h3 * i[3:0]; end
         wt(3);
         @(posedge ref_clk) fwd_hit <= 1;
         wt(6);
         chk(decel_out, {15'h0000, !tab[i][8]});
         wt(16);
         chk({zero_clamp_out, coast_out}, (i == 0) ? 16'h0002 : 16'h0001);
         @(posedge ref_clk) begin fwd_hit <= 0; torque_mode_in <= 0; end
         wt(6);
      end
      $display("test stop methods done");
      wreg(`OTW_ADDR_ALLOC_A, 16'h8000);
      wreg(`OTW_ADDR_ALLOC_B, 16'h0008);
      @(posedge ref_clk) begin fwd_hit <= 1; rev_hit <= 1; end
      wt(6);
      chk({fwd_allow_r, rev_allow_r}, 16'h0000);
      wreg(`OTW_ADDR_CTRL, 16'h0001);
      wt(4);
      chk({fwd_allow_r, rev_allow_r}, 16'h0003);
      wt(HOLD + 8);
      chk(ot_warning_r, 16'h0000);
      $display("test limit disable done");
      conclude;
   end
endmodule // otw_overtravel_tb
